// ==== core/sync_bcd_decade_counter.sv ====
// Presettable BCD decade counter with a small software register port.
// Assumes control pins come from logic on core_clk; no synchronisers.
`timescale 1ns/1ps
module sync_bcd_decade_counter import bcd_counter_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sync_clear_n,
  input wire logic parallel_load_n,
  input wire logic parallel_count_enable,
  input wire logic trickle_count_enable,
  input wire logic preset_bit0,
  input wire logic preset_bit1,
  input wire logic preset_bit2,
  input wire logic preset_bit3,
  output logic count_bit0,
  output logic count_bit1,
  output logic count_bit2,
  output logic count_bit3,
  output logic ripple_carry_out,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata
);

  logic [CNT_W-1:0] count_q; // RULE_01
  logic gate_q;
  logic [CNT_W-1:0] sw_preset_q;
  logic seen_q;
  logic [TALLY_W-1:0] wraps_q;
  logic [TALLY_W-1:0] loads_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;

  logic wr_ctrl;
  logic wr_cmd;
  logic wr_preset;
  logic wr_status;
  logic wr_wraps;
  logic wr_loads;
  logic sw_clear;
  logic sw_load;
  logic clear_eff_n;
  logic load_eff_n;
  logic [CNT_W-1:0] pin_preset;
  logic illegal_now;
  logic wrap_evt;
  logic load_evt;

  count_ctrl_if ctl ();

  // Register write decode
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_cmd = reg_wr && (reg_addr == OFS_CMD);
  assign wr_preset = reg_wr && (reg_addr == OFS_SW_PRESET);
  assign wr_status = reg_wr && (reg_addr == OFS_STATUS);
  assign wr_wraps = reg_wr && (reg_addr == OFS_WRAPS);
  assign wr_loads = reg_wr && (reg_addr == OFS_LOADS);

  assign sw_clear = wr_cmd && reg_wdata[CMD_CLEAR_BIT];
  assign sw_load = wr_cmd && reg_wdata[CMD_LOAD_BIT];

  // Software commands only add to the pin controls
  assign clear_eff_n = sync_clear_n && !sw_clear;
  assign load_eff_n = parallel_load_n && !sw_load;

  // Pin preset, bit 0 least significant
  assign pin_preset = {preset_bit3, preset_bit2, preset_bit1, preset_bit0}; // RULE_12

  // A pin load wins over a software load issued in the same cycle
  assign ctl.preset = !parallel_load_n ? pin_preset : sw_preset_q; // RULE_03
  assign ctl.cur = count_q;

  assign illegal_now = (count_q > BCD_MAX);
  assign wrap_evt = (ctl.mode == MODE_COUNT) && (count_q == BCD_MAX);
  assign load_evt = (ctl.mode == MODE_LOAD);

  bcd_mode_decode u_decode (
    .clear_n(clear_eff_n),
    .load_n(load_eff_n),
    .par_en(parallel_count_enable),
    .trk_en(trickle_count_enable),
    .gate(gate_q),
    .ctl(ctl.decoder)
  );

  bcd_next_state u_step (
    .ctl(ctl.stepper)
  );

  // Count register, all bits on one edge
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count_q <= CNT_ZERO;
    end else begin
      count_q <= ctl.nxt; // RULE_02 RULE_10
    end
  end

  assign count_bit0 = count_q[0]; // RULE_12
  assign count_bit1 = count_q[1];
  assign count_bit2 = count_q[2];
  assign count_bit3 = count_q[3];

  // Carry is combinational from state and trickle enable
  assign ripple_carry_out = trickle_count_enable && (count_q == BCD_MAX); // RULE_09 RULE_11

  // Count gate
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gate_q <= CTRL_GATE_RST;
    end else if (wr_ctrl) begin
      gate_q <= reg_wdata[CTRL_GATE_BIT];
    end
  end

  // Software preset value
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sw_preset_q <= SW_PRESET_RST;
    end else if (wr_preset) begin
      sw_preset_q <= reg_wdata[CNT_W-1:0];
    end
  end

  // Sticky illegal flag, write one to clear, set wins
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      seen_q <= 1'b0;
    end else if (illegal_now) begin
      seen_q <= 1'b1;
    end else if (wr_status && reg_wdata[ST_SEEN_BIT]) begin
      seen_q <= 1'b0;
    end
  end

  // Wrap tally, any write clears, wrap in same cycle wins
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wraps_q <= '0;
    end else if (wrap_evt) begin
      wraps_q <= wr_wraps ? TALLY_W'(1) : wraps_q + TALLY_W'(1);
    end else if (wr_wraps) begin
      wraps_q <= '0;
    end
  end

  // Load tally, same clearing scheme
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      loads_q <= '0;
    end else if (load_evt) begin
      loads_q <= wr_loads ? TALLY_W'(1) : loads_q + TALLY_W'(1);
    end else if (wr_loads) begin
      loads_q <= '0;
    end
  end

  // Read mux
  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      OFS_CTRL: rdata_d[CTRL_GATE_BIT] = gate_q;
      OFS_SW_PRESET: rdata_d[CNT_W-1:0] = sw_preset_q;
      OFS_STATUS: begin
        rdata_d[CNT_W-1:0] = count_q;
        rdata_d[ST_CARRY_BIT] = ripple_carry_out;
        rdata_d[ST_SEEN_BIT] = seen_q;
        rdata_d[ST_NOW_BIT] = illegal_now;
      end
      OFS_WRAPS: rdata_d[TALLY_W-1:0] = wraps_q;
      OFS_LOADS: rdata_d[TALLY_W-1:0] = loads_q;
      default: rdata_d = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

  // Checks

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (!rstn);

  logic counting;
  assign counting = (ctl.mode == MODE_COUNT);

  property p_clear;
    !sync_clear_n |=> (count_q == CNT_ZERO);
  endproperty
  a_clear: assert property (p_clear) // RULE_05
    else $error("clear did not zero the count");

  property p_load;
    clear_eff_n && !parallel_load_n |=> (count_q == $past(pin_preset));
  endproperty
  a_load: assert property (p_load) // RULE_04
    else $error("load did not copy the preset inputs");

  property p_load_any;
    sync_clear_n && !sw_clear && !parallel_load_n && (pin_preset <= BCD_MAX)
      |=> (count_q <= BCD_MAX);
  endproperty
  a_load_any: assert property (p_load_any) // RULE_03
    else $error("legal preset did not give a legal count");

  property p_hold;
    clear_eff_n && load_eff_n
      && !(parallel_count_enable && trickle_count_enable) |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold) // RULE_07
    else $error("count moved without both enables");

  property p_step;
    counting && (count_q < BCD_MAX) |=> (count_q == $past(count_q) + CNT_W'(1));
  endproperty
  a_step: assert property (p_step) // RULE_08
    else $error("count did not step by one");

  property p_wrap;
    counting && (count_q == BCD_MAX) ##1 counting |=> (count_q == CNT_W'(1));
  endproperty
  a_wrap: assert property (p_wrap) // RULE_08
    else $error("nine did not wrap through zero");

  property p_recover;
    counting && illegal_now ##1 counting |=> !illegal_now;
  endproperty
  a_recover: assert property (p_recover) // RULE_06
    else $error("illegal count not recovered in two counts");

  property p_stay_legal;
    !illegal_now && load_eff_n |=> !illegal_now;
  endproperty
  a_stay_legal: assert property (p_stay_legal) // RULE_01
    else $error("legal count left the decade");

  property p_carry;
    ripple_carry_out |-> count_bit3 && !count_bit2 && !count_bit1 && count_bit0
      && trickle_count_enable;
  endproperty
  a_carry: assert property (p_carry) // RULE_09
    else $error("carry high outside count nine");

  property p_carry_on;
    trickle_count_enable && (count_q == BCD_MAX) |-> ripple_carry_out;
  endproperty
  a_carry_on: assert property (p_carry_on) // RULE_09
    else $error("carry low at nine with trickle enable");

  property p_seen;
    illegal_now |=> seen_q;
  endproperty
  a_seen: assert property (p_seen)
    else $error("illegal flag not set");

  property p_rdata_idle;
    !reg_rd |=> (reg_rdata == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside the read slot");

  property p_sw_clear;
    sw_clear |=> (count_q == CNT_ZERO);
  endproperty
  a_sw_clear: assert property (p_sw_clear) // RULE_05
    else $error("command clear did not zero the count");

  property p_sw_load;
    clear_eff_n && parallel_load_n && sw_load |=> (count_q == $past(sw_preset_q));
  endproperty
  a_sw_load: assert property (p_sw_load) // RULE_04
    else $error("command load did not copy the software preset");

  property p_gate_off;
    clear_eff_n && load_eff_n && !gate_q |=> $stable(count_q);
  endproperty
  a_gate_off: assert property (p_gate_off) // RULE_07
    else $error("count moved with the gate closed");

  property p_nine_wrap;
    counting && (count_q == BCD_MAX) |=> (count_q == CNT_ZERO);
  endproperty
  a_nine_wrap: assert property (p_nine_wrap) // RULE_08
    else $error("nine did not step to zero");

  property p_carry_off;
    !trickle_count_enable |-> !ripple_carry_out;
  endproperty
  a_carry_off: assert property (p_carry_off) // RULE_09
    else $error("carry high without trickle enable");

  property p_gate_wr;
    wr_ctrl |=> (gate_q == $past(reg_wdata[CTRL_GATE_BIT]));
  endproperty
  a_gate_wr: assert property (p_gate_wr)
    else $error("gate write did not land");

  property p_seen_clr;
    !illegal_now && wr_status && reg_wdata[ST_SEEN_BIT] |=> !seen_q;
  endproperty
  a_seen_clr: assert property (p_seen_clr)
    else $error("illegal flag not cleared");

  property p_wraps_inc;
    wrap_evt && !wr_wraps |=> (wraps_q == $past(wraps_q) + TALLY_W'(1));
  endproperty
  a_wraps_inc: assert property (p_wraps_inc)
    else $error("wrap tally did not step");

  property p_wraps_clr;
    wr_wraps && !wrap_evt |=> (wraps_q == '0);
  endproperty
  a_wraps_clr: assert property (p_wraps_clr)
    else $error("wrap tally not cleared");

  property p_loads_inc;
    load_evt && !wr_loads |=> (loads_q == $past(loads_q) + TALLY_W'(1));
  endproperty
  a_loads_inc: assert property (p_loads_inc)
    else $error("load tally did not step");

  property p_loads_clr;
    wr_loads && !load_evt |=> (loads_q == '0);
  endproperty
  a_loads_clr: assert property (p_loads_clr)
    else $error("load tally not cleared");

  property p_rdata_status;
    reg_rd && (reg_addr == OFS_STATUS) |=> (reg_rdata[CNT_W-1:0] == $past(count_q));
  endproperty
  a_rdata_status: assert property (p_rdata_status)
    else $error("status read did not return the count");

endmodule

// ==== core/bcd_counter_pkg.sv ====
// Constants and types for the synchronous BCD decade counter.
// Assumes a single clock domain and a synchronous active-low reset.
// Function
// RULE_01 - Hold 4-bit BCD count, normally 0-9
// RULE_02 - All count bits update on same edge
// RULE_03 - Preset accepts any value 0 to 9
// RULE_04 - Load low copies data, ignores enables
// RULE_05 - Clear low zeroes count, beats everything
// RULE_06 - Illegal 10-15 recovers within two counts
// RULE_07 - Count only when both enables high
// RULE_08 - Step up by one, nine wraps zero
// RULE_09 - Carry high when trickle enable and nine
// RULE_10 - Only levels at the edge matter
// RULE_11 - Cascade carry into next trickle enable
// RULE_12 - Bit 0 least, bit 3 most significant
// RULE_13 - Fixed illegal-state map, legal within two
package bcd_counter_pkg;
  localparam int CNT_W = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int TALLY_W = 16;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] BCD_MAX = 4'h9;
  // Next value while counting, indexed by current value
  localparam logic [15:0][3:0] STEP_TABLE = {
    4'h2, 4'hf, 4'h4, 4'hd, 4'h6, 4'hb, 4'h0, 4'h9,
    4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_SW_PRESET = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_WRAPS = 8'h10;
  localparam logic [7:0] OFS_LOADS = 8'h14;
  localparam int CTRL_GATE_BIT = 0;
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_LOAD_BIT = 1;
  localparam int ST_CARRY_BIT = 4;
  localparam int ST_SEEN_BIT = 5;
  localparam int ST_NOW_BIT = 6;
  localparam logic CTRL_GATE_RST = 1'b1;
  localparam logic [3:0] SW_PRESET_RST = 4'h0;
  typedef enum logic [1:0] {
    MODE_HOLD,
    MODE_COUNT,
    MODE_LOAD,
    MODE_CLEAR
  } mode_t;
endpackage

// ==== core/count_ctrl_if.sv ====
// Carries mode, preset and count between counter submodules.
// Assumes all users share one clock.
`timescale 1ns/1ps
interface count_ctrl_if import bcd_counter_pkg::*; ();
  mode_t mode;
  logic [CNT_W-1:0] preset;
  logic [CNT_W-1:0] cur;
  logic [CNT_W-1:0] nxt;
  modport decoder (output mode);
  modport stepper (input mode, input preset, input cur, output nxt);
  modport owner (input mode, input nxt, output preset, output cur);
endinterface

// ==== core/bcd_mode_decode.sv ====
// Priority decode of clear, load and count enables.
// Assumes inputs are already in the core_clk domain.
`timescale 1ns/1ps
module bcd_mode_decode import bcd_counter_pkg::*; (
  input wire logic clear_n,
  input wire logic load_n,
  input wire logic par_en,
  input wire logic trk_en,
  input wire logic gate,
  count_ctrl_if.decoder ctl
);
  always_comb begin
    if (!clear_n) begin
      ctl.mode = MODE_CLEAR; // RULE_05
    end else if (!load_n) begin
      ctl.mode = MODE_LOAD; // RULE_04
    end else if (par_en && trk_en && gate) begin
      ctl.mode = MODE_COUNT; // RULE_07
    end else begin
      ctl.mode = MODE_HOLD;
    end
  end
endmodule

// ==== core/bcd_next_state.sv ====
// Next count value for each mode.
// Assumes mode is decoded with clear first.
`timescale 1ns/1ps
module bcd_next_state import bcd_counter_pkg::*; (
  count_ctrl_if.stepper ctl
);
  always_comb begin
    case (ctl.mode)
      MODE_CLEAR: ctl.nxt = CNT_ZERO; // RULE_05
      MODE_LOAD: ctl.nxt = ctl.preset; // RULE_03
      MODE_COUNT: ctl.nxt = STEP_TABLE[ctl.cur]; // RULE_06 RULE_08 RULE_13
      MODE_HOLD: ctl.nxt = ctl.cur;
      default: ctl.nxt = ctl.cur;
    endcase
  end
endmodule

// ==== sim/next_stage_model.sv ====
// Behavioural next decade stage fed by the carry of the block.
// Assumes it shares core_clk and the synchronous reset with the block.
`timescale 1ns/1ps
module next_stage_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic count_en,
  input wire logic carry_in,
  output logic [3:0] digit
);
  // Steps only when the lower digit's carry enables it
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      digit <= 4'h0;
    end else if (count_en && carry_in) begin
      digit <= (digit == 4'h9) ? 4'h0 : digit + 4'h1;
    end
  end
endmodule

// ==== sim/test_sync_bcd_decade_counter.sv ====
// Self-checking bench for the decade counter with a cascaded stage.
// Assumes a 100 MHz core_clk and a fixed random seed.
`timescale 1ns/1ps
module test_sync_bcd_decade_counter;
  import bcd_counter_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic sync_clear_n = 1'b1;
  logic parallel_load_n = 1'b1;
  logic parallel_count_enable = 1'b0;
  logic trickle_count_enable = 1'b0;
  logic preset_bit0 = 1'b0;
  logic preset_bit1 = 1'b0;
  logic preset_bit2 = 1'b0;
  logic preset_bit3 = 1'b0;
  logic count_bit0, count_bit1, count_bit2, count_bit3, ripple_carry_out;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] digit;
  int errors = 0;
  int checks_done = 0;
  int m = 0;
  int tens = 0;
  int gate = 1;
  int sp = 0;
  int rexp = 0;
  int seen = 0;
  int wraps = 0;
  int loads = 0;
  int nxt[16] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 0, 11, 6, 13, 4, 15, 2};
  logic [7:0] wa[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  logic [7:0] ra[6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24};

  always #5 core_clk = ~core_clk;

  sync_bcd_decade_counter sync_bcd_decade_counter_inst (.core_clk(core_clk), .rstn(rstn),
    .sync_clear_n(sync_clear_n), .parallel_load_n(parallel_load_n),
    .parallel_count_enable(parallel_count_enable), .trickle_count_enable(trickle_count_enable),
    .preset_bit0(preset_bit0), .preset_bit1(preset_bit1), .preset_bit2(preset_bit2),
    .preset_bit3(preset_bit3), .count_bit0(count_bit0), .count_bit1(count_bit1),
    .count_bit2(count_bit2), .count_bit3(count_bit3), .ripple_carry_out(ripple_carry_out),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  next_stage_model next_stage_model_inst (.core_clk(core_clk), .rstn(rstn),
    .count_en(parallel_count_enable), .carry_in(ripple_carry_out), .digit(digit));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One clock: update the model from the levels sampled at the edge, then drive
  task automatic cyc(input logic [3:0] d, input logic cn, input logic ln, input logic p,
    input logic t, input logic w, input logic r, input logic [7:0] a, input logic [31:0] wd);
    int nm;
    logic cmd;
    logic clr;
    logic ld;
    logic stp;
    @(posedge core_clk);
    nm = m;
    rexp = 0;
    cmd = reg_wr && reg_addr == OFS_CMD;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: rexp = gate;
        OFS_SW_PRESET: rexp = sp;
        OFS_STATUS: rexp = m | ((trickle_count_enable && m == 9) << 4) | (seen << 5)
          | ((m > 9) << 6);
        OFS_WRAPS: rexp = wraps;
        OFS_LOADS: rexp = loads;
        default: rexp = 0;
      endcase
    end
    if (parallel_count_enable && trickle_count_enable && m == 9) tens = (tens + 1) % 10;
    if (!sync_clear_n || (cmd && reg_wdata[0])) nm = 0;
    else if (!parallel_load_n) nm = {preset_bit3, preset_bit2, preset_bit1, preset_bit0};
    else if (cmd && reg_wdata[1]) nm = sp;
    else if (parallel_count_enable && trickle_count_enable && gate == 1) nm = nxt[m];
    clr = !sync_clear_n || (cmd && reg_wdata[0]);
    ld = !clr && (!parallel_load_n || (cmd && reg_wdata[1]));
    stp = !clr && !ld && parallel_count_enable && trickle_count_enable && gate == 1;
    // Status flag and tallies: the event wins over a clearing write
    if (m > 9) seen = 1;
    else if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[5]) seen = 0;
    if (stp && m == 9) wraps = (reg_wr && reg_addr == OFS_WRAPS) ? 1 : (wraps + 1) % 65536;
    else if (reg_wr && reg_addr == OFS_WRAPS) wraps = 0;
    if (ld) loads = (reg_wr && reg_addr == OFS_LOADS) ? 1 : (loads + 1) % 65536;
    else if (reg_wr && reg_addr == OFS_LOADS) loads = 0;
    if (reg_wr && reg_addr == OFS_CTRL) gate = reg_wdata[0];
    if (reg_wr && reg_addr == OFS_SW_PRESET) sp = reg_wdata[3:0];
    m = nm;
    {preset_bit3, preset_bit2, preset_bit1, preset_bit0} <= d;
    sync_clear_n <= cn;
    parallel_load_n <= ln;
    parallel_count_enable <= p;
    trickle_count_enable <= t;
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= wd;
    #1;
    chk("count", {28'h0, count_bit3, count_bit2, count_bit1, count_bit0}, 32'(m));
    chk("carry", {31'h0, ripple_carry_out}, 32'(t && m == 9));
    chk("next_digit", {28'h0, digit}, 32'(tens));
    chk("rdata", reg_rdata, 32'(rexp));
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    logic [3:0] d;
    int op;
    void'($urandom(30));
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    // Clear beats load and enables, then preset seven and count through the wrap
    cyc(4'h3, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 32'h0);
    cyc(4'h7, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 32'h0);
    repeat (7) cyc(4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 32'h0);
    repeat (2) cyc(4'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 32'h0);
    // Software preset, gate off, status and unmapped reads, command clear
    cyc(4'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, OFS_SW_PRESET, 32'hd);
    cyc(4'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, OFS_CMD, 32'h2);
    cyc(4'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, OFS_STATUS, 32'h0);
    cyc(4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, OFS_CTRL, 32'h0);
    cyc(4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, OFS_CTRL, 32'h0);
    cyc(4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, OFS_CTRL, 32'h1);
    cyc(4'h5, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, OFS_CMD, 32'h1);
    cyc(4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h24, 32'h0);
    for (int i = 0; i < 3000; i++) begin
      d = 4'($urandom % 16);
      op = $urandom % 4;
      cyc(d, 1'(($urandom % 16) != 0), 1'(($urandom % 8) != 0), 1'(($urandom % 4) != 0),
        1'(($urandom % 4) != 0), 1'(op == 0), 1'(op == 1),
        (op == 0) ? wa[$urandom % 7] : ra[$urandom % 6], $urandom);
    end
    report_and_stop();
  end
endmodule
